// [rtl/udsp_defines.vh]
`ifndef UDSP_DEFINES_VH
`define UDSP_DEFINES_VH

// ==============================================================
// Register offsets
`define UDSP_OFS_BURST 6'h1a
`define UDSP_OFS_STATUS 6'h1c
`define UDSP_OFS_PARTID 6'h1d
`define UDSP_OFS_REVID 6'h1e
`define UDSP_OFS_MODE 6'h20

// ==============================================================
// Field positions
`define UDSP_ST_SUPPLY 3
`define UDSP_ST_PULSE 2
`define UDSP_ST_STUCK 1
`define UDSP_ST_CRC 0
`define UDSP_BR_INPHASE 7
`define UDSP_BR_CNT_HI 5
`define UDSP_BR_CNT_LO 0
`define UDSP_MD_IO_HI 1
`define UDSP_MD_IO_LO 0
`define UDSP_MD_DG_HI 5
`define UDSP_MD_DG_LO 2

// ==============================================================
// Reset values and codes
`define UDSP_RST_BYTE 8'h00
`define UDSP_IO_MODE2 2'h2
`define UDSP_CNT_CONT 6'h00

// ==============================================================
// Serial frame layout: read flag, 6-bit address, spare bit, data byte
`define UDSP_FRAME_BITS 5'h10
`define UDSP_ADDR_BITS 5'h08
`define UDSP_LAST_BIT 5'h0f
`define UDSP_ADDR_LAST 5'h07

// ==============================================================
// Stuck detection step, in nanoseconds, and clock period
`define UDSP_STUCK_STEP_NS 1000
`define UDSP_CLK_PERIOD_NS 10

`endif

// [rtl/udsp_status_pins.v]
// What this block does
// - Status bit 3 shows drive supply ready
// - Bit 2 flags a burst pulse count that differs from the programmed count
// - Bit 1 flags drive stuck past deglitch
// - Bit 0 flags nonvolatile memory CRC failure
// - Status at 0x1C, reset zero, upper zero
// - Read-only identification code at 0x1D
// - Read-only silicon revision code at 0x1E
// - Registers configured only through serial port
// - Mode 2 complementary decode of inputs
// - Mode 2 in-phase grounds both on 0/1
// - In-phase select switches both outputs together
`timescale 1ns/1ps
`default_nettype none
`include "udsp_defines.vh"

module udsp_status_pins #(
  parameter [7:0] PART_CODE = 8'h5a,     // Arbitrary value
  parameter [7:0] REVISION_CODE = 8'h01, // Arbitrary value
  parameter integer STEP_CYC = `UDSP_STUCK_STEP_NS / `UDSP_CLK_PERIOD_NS
) (
  input wire REF_CLK,
  input wire RESETN,
  input wire SPI_CS_N,
  input wire SPI_SCLK,
  input wire SPI_MOSI,
  output wire SPI_MISO,
  output wire SPI_MISO_OE,
  input wire DRIVE_INPUT_FIRST,
  input wire DRIVE_INPUT_SECOND,
  input wire BURST_WINDOW,
  input wire DRIVE_SUPPLY_OK,
  input wire NVM_CRC_FAIL,
  output wire LOW_SIDE_OUT_FIRST_O,
  output wire LOW_SIDE_OUT_FIRST_OE,
  output wire LOW_SIDE_OUT_SECOND_O,
  output wire LOW_SIDE_OUT_SECOND_OE
);

  // ==============================================================
  // Serial port
  reg sclk_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] rx_q;
  reg [7:0] tx_q;
  reg miso_q;
  reg miso_oe_q;
  reg [7:0] burst_cfg_q;
  reg [7:0] mode_cfg_q;
  reg [7:0] rd_data;
  wire [7:0] status_byte;
  // SCLK is sampled on REF_CLK, so each SCLK phase must last at least one
  // full REF_CLK cycle, or an edge is missed and the frame slips by one bit
  wire sclk_rise = SPI_SCLK & ~sclk_q;
  wire sclk_fall = ~SPI_SCLK & sclk_q;
  wire [15:0] rx_next = {rx_q[14:0], SPI_MOSI};

  // Read mux; unmapped addresses return zero
  // The address is complete at the eighth rise, so the byte is picked then
  always @* begin
    case (rx_next[6:1])
      `UDSP_OFS_BURST: rd_data = burst_cfg_q;
      `UDSP_OFS_MODE: rd_data = mode_cfg_q;
      `UDSP_OFS_STATUS: rd_data = status_byte;
      `UDSP_OFS_PARTID: rd_data = PART_CODE;
      `UDSP_OFS_REVID: rd_data = REVISION_CODE;
      default: rd_data = `UDSP_RST_BYTE;
    endcase
  end

  // Frame shift, read load and register write
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      tx_q <= `UDSP_RST_BYTE;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      burst_cfg_q <= `UDSP_RST_BYTE;
      mode_cfg_q <= `UDSP_RST_BYTE;
    end else begin
      sclk_q <= SPI_SCLK;
      miso_oe_q <= ~SPI_CS_N;
      // Select high aborts a partial frame: count restarts, nothing is written
      if (SPI_CS_N) begin
        bit_cnt_q <= 5'h00;
        miso_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rx_q <= rx_next;
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `UDSP_ADDR_LAST) begin
            tx_q <= rd_data;
          end
          // Only the serial port writes configuration
          if (bit_cnt_q == `UDSP_LAST_BIT && !rx_q[14]) begin
            if (rx_q[13:8] == `UDSP_OFS_BURST) begin
              burst_cfg_q <= rx_next[7:0];
            end
            if (rx_q[13:8] == `UDSP_OFS_MODE) begin
              mode_cfg_q <= rx_next[7:0];
            end
          end
        end
        if (sclk_fall && bit_cnt_q >= `UDSP_ADDR_BITS && bit_cnt_q < `UDSP_FRAME_BITS) begin
          miso_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // Serial data and its enable leave straight from flops
  assign SPI_MISO = miso_q;
  assign SPI_MISO_OE = miso_oe_q;

  // ==============================================================
  // Burst supervision
  reg win_q;
  reg first_q;
  reg [6:0] pulse_cnt_q;
  reg [15:0] hold_cnt_q;
  reg pulse_flt_q;
  reg stuck_flt_q;
  reg supply_q;
  reg crc_q;
  wire [5:0] want_cnt = burst_cfg_q[`UDSP_BR_CNT_HI:`UDSP_BR_CNT_LO];
  wire [3:0] dg_sel = mode_cfg_q[`UDSP_MD_DG_HI:`UDSP_MD_DG_LO];
  wire [15:0] stuck_limit = (dg_sel + 16'h0001) * STEP_CYC[15:0];
  // Status byte; the reserved upper nibble always reads zero
  assign status_byte = {4'h0, supply_q, pulse_flt_q, stuck_flt_q, crc_q};

  // Pulse count, stuck timer and live flags
  // Both faults are cleared only by the next burst start, never by a read,
  // so a host that polls late still sees what went wrong in the last burst
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      win_q <= 1'b0;
      first_q <= 1'b0;
      pulse_cnt_q <= 7'h00;
      hold_cnt_q <= 16'h0000;
      pulse_flt_q <= 1'b0;
      stuck_flt_q <= 1'b0;
      supply_q <= 1'b0;
      crc_q <= 1'b0;
    end else begin
      win_q <= BURST_WINDOW;
      first_q <= DRIVE_INPUT_FIRST;
      supply_q <= DRIVE_SUPPLY_OK;
      crc_q <= NVM_CRC_FAIL;
      if (BURST_WINDOW && !win_q) begin
        pulse_cnt_q <= 7'h00;
        hold_cnt_q <= 16'h0000;
        stuck_flt_q <= 1'b0;
        pulse_flt_q <= 1'b0;
      end else if (BURST_WINDOW) begin
        // Counter saturates so an overlong burst cannot wrap back to a match
        if (DRIVE_INPUT_FIRST && !first_q && pulse_cnt_q != 7'h7f) begin
          pulse_cnt_q <= pulse_cnt_q + 7'h01;
        end
        // Any change of the first input restarts the stuck timer
        if (DRIVE_INPUT_FIRST != first_q) begin
          hold_cnt_q <= 16'h0000;
        end else if (hold_cnt_q != 16'hffff) begin
          hold_cnt_q <= hold_cnt_q + 16'h0001;
        end
        if (hold_cnt_q >= stuck_limit) begin
          stuck_flt_q <= 1'b1;
        end
      end else if (win_q) begin
        // Burst over: compare against programmed count unless continuous
        pulse_flt_q <= (want_cnt != `UDSP_CNT_CONT) && (pulse_cnt_q != {1'b0, want_cnt});
      end
    end
  end

  // ==============================================================
  // Direct pin decode in mode 2
  reg out_first_d;
  reg out_second_d;
  reg out_first_q;
  reg out_second_q;
  // Io mode and in-phase select both come from configuration flops
  wire mode2 = mode_cfg_q[`UDSP_MD_IO_HI:`UDSP_MD_IO_LO] == `UDSP_IO_MODE2;
  wire inphase = burst_cfg_q[`UDSP_BR_INPHASE];

  // Decode the drive inputs; any other io mode leaves both outputs floating
  always @* begin
    out_first_d = 1'b0;
    out_second_d = 1'b0;
    if (mode2 && inphase) begin
      out_first_d = ~DRIVE_INPUT_FIRST & DRIVE_INPUT_SECOND;
      out_second_d = ~DRIVE_INPUT_FIRST & DRIVE_INPUT_SECOND;
    end else if (mode2) begin
      out_first_d = DRIVE_INPUT_FIRST & ~DRIVE_INPUT_SECOND;
      out_second_d = ~DRIVE_INPUT_FIRST & DRIVE_INPUT_SECOND;
    end
  end

  // Registered pull-down enables
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_first_q <= 1'b0;
      out_second_q <= 1'b0;
    end else begin
      out_first_q <= out_first_d;
      out_second_q <= out_second_d;
    end
  end

  // Outputs only pull to ground; the enable chooses ground or high impedance.
  // Registered enables keep decode glitches off the pins, at one cycle of lag
  assign LOW_SIDE_OUT_FIRST_O = 1'b0;
  assign LOW_SIDE_OUT_SECOND_O = 1'b0;
  assign LOW_SIDE_OUT_FIRST_OE = out_first_q;
  assign LOW_SIDE_OUT_SECOND_OE = out_second_q;

endmodule

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn = 1'b0, d1 = 1'b0, d2 = 1'b0, bw = 1'b0, sup = 1'b0, crc = 1'b0;
  wire cs_n, sclk, mosi, miso, moe, o1, oe1, o2, oe2;
  int errors = 0;
  int comparisons = 0;
  udsp_status_pins #(.STEP_CYC(2)) i_dut (.REF_CLK(clk), .RESETN(rstn), .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(moe),
    .DRIVE_INPUT_FIRST(d1), .DRIVE_INPUT_SECOND(d2), .BURST_WINDOW(bw), .DRIVE_SUPPLY_OK(sup),
    .NVM_CRC_FAIL(crc), .LOW_SIDE_OUT_FIRST_O(o1), .LOW_SIDE_OUT_FIRST_OE(oe1),
    .LOW_SIDE_OUT_SECOND_O(o2), .LOW_SIDE_OUT_SECOND_OE(oe2));
  udsp_host i_host (.clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  // ==========
  // Clock, watchdog and shared tasks
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    close_out;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_host.xfer({1'b0, a, 1'b0, d}, r);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_host.xfer({1'b1, a, 1'b0, 8'h00}, r);
    chk("register", e, r);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      d1 <= 1'b1;
      repeat (4) @(posedge clk);
      d1 <= 1'b0;
    end
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(6'h1c, 8'h00);
    rd(6'h1d, 8'h5a);
    rd(6'h1e, 8'h01);
    wr(6'h1d, 8'hff);
    wr(6'h1c, 8'hff);
    rd(6'h1d, 8'h5a);
    rd(6'h1c, 8'h00);
    rd(6'h3f, 8'h00);
    sup <= 1'b1;
    rd(6'h1c, 8'h08);
    crc <= 1'b1;
    rd(6'h1c, 8'h09);
    for (int v = 1; v < 3; v++) begin
      @(posedge clk) {d1, d2} <= v[1:0];
      repeat (2) @(posedge clk);
      chk("pins off", 8'h00, {6'h00, oe1, oe2});
    end
    wr(6'h20, 8'h3e);
    for (int ip = 0; ip < 2; ip++) begin
      wr(6'h1a, {ip[0], 7'h02});
      for (int v = 0; v < 4; v++) begin
        @(posedge clk) {d1, d2} <= v[1:0];
        repeat (2) @(posedge clk);
        chk("pins", {6'h00, (ip == 1) ? v == 1 : v == 2, v == 1},
          {6'h00, oe1, oe2});
      end
    end
    {d1, d2} <= 2'h0;
    bw <= 1'b1;
    pulses(1);
    bw <= 1'b0;
    rd(6'h1c, 8'h0d);
    rd(6'h1c, 8'h0d);
    bw <= 1'b1;
    pulses(2);
    repeat (40) @(posedge clk);
    bw <= 1'b0;
    rd(6'h1c, 8'h0b);
    close_out;
  end
endmodule
`default_nettype wire

// [tb/udsp_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module udsp_checker (
  input wire REF_CLK,
  input wire RESETN,
  input wire SPI_CS_N,
  input wire SPI_MISO,
  input wire SPI_MISO_OE,
  input wire DRIVE_INPUT_FIRST,
  input wire DRIVE_INPUT_SECOND,
  input wire LOW_SIDE_OUT_FIRST_O,
  input wire LOW_SIDE_OUT_FIRST_OE,
  input wire LOW_SIDE_OUT_SECOND_O,
  input wire LOW_SIDE_OUT_SECOND_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // ==========
  // Pin decode and serial port checks
  wire [1:0] oe = {LOW_SIDE_OUT_FIRST_OE, LOW_SIDE_OUT_SECOND_OE};
  wire [1:0] din = {DRIVE_INPUT_FIRST, DRIVE_INPUT_SECOND};
  a_first_pull: assert property (!LOW_SIDE_OUT_FIRST_O) else $error("first high");
  a_second_pull: assert property (!LOW_SIDE_OUT_SECOND_O) else $error("second high");
  a_both_ground: assert property (oe == 2'h3 |-> $past(din) == 2'h1) else $error("both");
  a_second_gnd: assert property (oe[0] |-> $past(din) == 2'h1) else $error("second");
  a_first_gnd: assert property (oe[1] |-> ^$past(din)) else $error("first");
  a_equal_hiz: assert property (!(^$past(din)) |-> oe == 2'h0) else $error("equal");
  a_miso_idle: assert property (SPI_CS_N && $past(SPI_CS_N) |-> !SPI_MISO) else $error("miso");
  a_oe_follows: assert property (SPI_MISO_OE == !$past(SPI_CS_N)) else $error("oe");
  c_both: cover property (oe == 2'h3);
  c_first: cover property (oe == 2'h2);
  c_frame: cover property ($fell(SPI_CS_N));
endmodule
bind udsp_status_pins udsp_checker i_chk (.REF_CLK, .RESETN, .SPI_CS_N, .SPI_MISO, .SPI_MISO_OE,
  .DRIVE_INPUT_FIRST, .DRIVE_INPUT_SECOND, .LOW_SIDE_OUT_FIRST_O, .LOW_SIDE_OUT_FIRST_OE,
  .LOW_SIDE_OUT_SECOND_O, .LOW_SIDE_OUT_SECOND_OE);
`default_nettype wire

// [tb/udsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module udsp_host (
  input wire logic clk,
  input wire logic miso,
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic mosi = 1'b0
);
  // Idle data line toggles so a stale bit is never taken as valid
  always @(posedge clk) if (cs_n) mosi <= ~mosi;
  // One whole frame; read bits come from the last eight rises
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) begin
        sclk <= 1'b0;
        mosi <= f[i];
      end
      repeat (2) @(posedge clk);
      @(posedge clk) begin
        sclk <= 1'b1;
        r = {r[6:0], miso};
      end
      @(posedge clk);
    end
    @(posedge clk) sclk <= 1'b0;
    @(posedge clk) cs_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire
